// ===== common/cmd_streamer_pkg.sv
// Constants, header layout and carrier types for the ring command fetch parser.
// Assumes one engine clock and a memory port that returns whole fetch lines in request order.
// Notes on behaviour
// - Only register writes inside 0x2000..0x27FF are claimed; others ignored.
// - A ring tail register write kicks off the fetch DMA; a ring start write stops it.
// - Fetch address is ring start plus the DMA head copy.
// - Each memory request asks for exactly one fetch line.
// - Fetch FIFO holds 8 lines; a request first reserves its line slot.
// - DMA keeps head and tail copies and advances its head per request.
// - DMA stops requesting when its head copy equals the tail.
// - Parser runs while the FIFO holds data and stalls while it is empty.
// - Header dword routes a command to vertex fetch, compute or parser.
// - Forwarded packets carry body dwords only, header stripped.
// - Architectural head advances only after a command completes.
// - Ring is empty whenever architectural head equals tail.
// - Pipeline type 3h in bits 28:27 is 3D; opcode 26:24, sub-opcode 23:16.
// - Ring context-switch requests stop fetch and parsing and are acknowledged.
// - Runs independently of the codec streamer; engines sync by semaphores only.
// - Commands execute strictly one after another on one submit port.
// - A pipeline-select command chooses 3D or media/compute mode.
package cmd_streamer_pkg;
  localparam int unsigned LINE_DW = 16;
  localparam int unsigned LINE_BITS = 512;
  localparam int unsigned FIFO_LINES = 8;
  localparam logic [3:0] FIFO_LINES_C = 4'h8;
  localparam logic [31:0] LINE_BYTES = 32'h0000_0040;
  localparam logic [31:0] DW_BYTES = 32'h0000_0004;
  localparam logic [31:0] MMIO_LO = 32'h0000_2000;
  localparam logic [31:0] MMIO_HI = 32'h0000_27FF;
  localparam logic [31:0] RING_TAIL_OFS = 32'h0000_2030;
  localparam logic [31:0] RING_START_OFS = 32'h0000_2038;
  localparam logic [31:0] RING_LEN_OFS = 32'h0000_203C;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [31:0] RING_LEN_RST = 32'h0000_1000;
  localparam logic [2:0] CLIENT_MI = 3'h0;
  localparam logic [2:0] CLIENT_RENDER = 3'h3;
  localparam logic [1:0] TYPE_3D = 2'h3;
  localparam logic [1:0] TYPE_PIPESEL = 2'h1;
  localparam logic [2:0] OPC_PIPESEL = 3'h1;
  localparam logic [7:0] SUB_PIPESEL = 8'h04;
  localparam logic [5:0] MI_SEMA_WAIT = 6'h1C;

  typedef struct packed {
    logic [2:0] client;
    logic [1:0] ptype;
    logic [2:0] opc;
    logic [7:0] sub;
    logic [7:0] ctl;
    logic [7:0] len;
  } hdr_t;

  typedef struct packed {
    logic [31:0] data;
    logic last;
  } pkt_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } mmio_t;

  typedef enum logic [1:0] {P_HDR, P_BODY, P_DONE} parse_state_t;
  typedef enum logic [1:0] {D_VF, D_CMP, D_SELF} dest_t;
endpackage

// ===== src/fetch_line_fifo.sv
// Eight-entry FIFO of fetch lines between the memory return path and the parser.
// Assumes the writer never pushes when full; the DMA reserves each slot before asking.
`timescale 1ns/1ps
module fetch_line_fifo (
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic push_i,
  input wire logic [cmd_streamer_pkg::LINE_BITS-1:0] line_i,
  input wire logic flush_i,
  // Drain side
  input wire logic pop_i,
  output logic [cmd_streamer_pkg::LINE_BITS-1:0] line_o,
  output logic empty_o,
  output logic [3:0] count_o
);
  logic [cmd_streamer_pkg::LINE_BITS-1:0] mem_q [cmd_streamer_pkg::FIFO_LINES];
  logic [2:0] wr_q, wr_d, rd_q, rd_d;
  logic [3:0] cnt_q, cnt_d;

  always_comb
  begin
    wr_d = wr_q + 3'(push_i);
    rd_d = rd_q + 3'(pop_i && !empty_o);
    cnt_d = cnt_q + 4'(push_i) - 4'(pop_i && !empty_o);
    if (flush_i)
    begin
      wr_d = 3'h0;
      rd_d = 3'h0;
      cnt_d = 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_q <= 3'h0;
      rd_q <= 3'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push_i)
      mem_q[wr_q] <= line_i;
  end

  assign line_o = mem_q[rd_q];
  assign empty_o = (cnt_q == 4'h0);
  assign count_o = cnt_q;
endmodule

// ===== src/ring_command_fetch_parser.sv
// Ring buffer command streamer front end: register window, line fetch DMA and header parser.
// Assumes ring start, length and tail are fetch-line aligned and reprogrammed only while idle.
`timescale 1ns/1ps
module ring_command_fetch_parser (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register write port
  input wire logic mmio_valid_i,
  input wire cmd_streamer_pkg::mmio_t mmio_i,
  output logic mmio_claim_o,
  // Memory read port
  output logic mem_req_valid_o,
  output logic [31:0] mem_req_addr_o,
  input wire logic mem_req_ready_i,
  input wire logic mem_rsp_valid_i,
  input wire logic [cmd_streamer_pkg::LINE_BITS-1:0] mem_rsp_line_i,
  // Vertex fetch and compute packet outputs
  output logic vf_valid_o,
  output cmd_streamer_pkg::pkt_t vf_pkt_o,
  input wire logic vf_ready_i,
  output logic cmp_valid_o,
  output cmd_streamer_pkg::pkt_t cmp_pkt_o,
  input wire logic cmp_ready_i,
  // Engine control and status
  input wire logic sema_i,
  input wire logic ctx_switch_i,
  output logic ctx_switch_ack_o,
  output logic [31:0] head_o,
  output logic ring_empty_o,
  output logic mode_3d_o
);
  logic [31:0] start_q, start_d, len_q, len_d, tail_q, tail_d;
  logic [31:0] head_q, head_d, dma_head_q, dma_head_d, addr_q, addr_d;
  logic fetch_en_q, fetch_en_d, stop_q, stop_d, ack_q, ack_d, claim_q, claim_d;
  logic req_q, req_d, empty_q, empty_d, mode_q, mode_d, sema_q, sema_d, flush;
  logic [3:0] infl_q, infl_d, fifo_cnt;
  logic [3:0] pos_q, pos_d;
  logic [7:0] rem_q, rem_d;
  logic [8:0] ndw_q, ndw_d;
  logic vfv_q, vfv_d, cmv_q, cmv_d;
  cmd_streamer_pkg::pkt_t vfp_q, vfp_d, cmp_q, cmp_d;
  cmd_streamer_pkg::parse_state_t st_q, st_d;
  cmd_streamer_pkg::dest_t dest_q, dest_d;
  cmd_streamer_pkg::hdr_t hdr;
  logic [cmd_streamer_pkg::LINE_BITS-1:0] fifo_line;
  logic fifo_empty, consume, in_win, vf_free, cm_free;
  logic [31:0] cur_dw, dma_next, head_sum;

  fetch_line_fifo u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .push_i(mem_rsp_valid_i),
    .line_i(mem_rsp_line_i),
    .flush_i(flush),
    .pop_i(consume && pos_q == 4'hF),
    .line_o(fifo_line),
    .empty_o(fifo_empty),
    .count_o(fifo_cnt)
  );

  // Register window and DMA: one line per request, slot reserved when the request is raised.
  always_comb
  begin
    in_win = mmio_valid_i && mmio_i.addr >= cmd_streamer_pkg::MMIO_LO
             && mmio_i.addr <= cmd_streamer_pkg::MMIO_HI;
    claim_d = in_win;
    start_d = start_q;
    len_d = len_q;
    tail_d = tail_q;
    fetch_en_d = fetch_en_q;
    stop_d = stop_q || ctx_switch_i;
    flush = 1'b0;
    dma_head_d = dma_head_q;
    req_d = req_q;
    addr_d = addr_q;
    infl_d = infl_q - 4'(mem_rsp_valid_i);
    dma_next = dma_head_q + cmd_streamer_pkg::LINE_BYTES;
    if (dma_next >= len_q)
      dma_next = cmd_streamer_pkg::PTR_RST;
    if (req_q && mem_req_ready_i)
    begin
      req_d = 1'b0;
      dma_head_d = dma_next;
    end
    else if (!req_q && fetch_en_q && !stop_q && dma_head_q != tail_q
             && fifo_cnt + infl_q < cmd_streamer_pkg::FIFO_LINES_C)
    begin
      req_d = 1'b1;
      addr_d = start_q + dma_head_q;
      infl_d = infl_d + 4'h1;
    end
    if (in_win && mmio_i.addr == cmd_streamer_pkg::RING_START_OFS)
    begin
      start_d = mmio_i.data;
      dma_head_d = cmd_streamer_pkg::PTR_RST;
      fetch_en_d = 1'b0;
      flush = 1'b1;
    end
    if (in_win && mmio_i.addr == cmd_streamer_pkg::RING_LEN_OFS)
      len_d = mmio_i.data;
    if (in_win && mmio_i.addr == cmd_streamer_pkg::RING_TAIL_OFS)
    begin
      tail_d = mmio_i.data;
      fetch_en_d = 1'b1;
      // A context switch request in the same cycle as the tail write still stops the ring.
      stop_d = ctx_switch_i;
    end
    ack_d = stop_d && st_q == cmd_streamer_pkg::P_HDR && !req_q && infl_q == 4'h0;
  end

  // Parser: one command at a time, header decoded then body streamed or consumed.
  always_comb
  begin
    cur_dw = fifo_line[{pos_q, 5'h00} +: 32];
    hdr = cur_dw;
    vf_free = !vfv_q || vf_ready_i;
    cm_free = !cmv_q || cmp_ready_i;
    st_d = st_q;
    dest_d = dest_q;
    rem_d = rem_q;
    ndw_d = ndw_q;
    mode_d = mode_q;
    sema_d = sema_q;
    head_d = head_q;
    consume = 1'b0;
    vfv_d = vfv_q && !vf_ready_i;
    cmv_d = cmv_q && !cmp_ready_i;
    vfp_d = vfp_q;
    cmp_d = cmp_q;
    head_sum = head_q + {21'h0, ndw_q, 2'h0};
    if (head_sum >= len_q)
      head_sum = head_sum - len_q;
    unique case (st_q)
      cmd_streamer_pkg::P_HDR:
        if (!fifo_empty && !empty_q && !stop_q)
        begin
          consume = 1'b1;
          rem_d = hdr.len;
          ndw_d = 9'h001;
          sema_d = 1'b0;
          dest_d = cmd_streamer_pkg::D_SELF;
          if (hdr.client == cmd_streamer_pkg::CLIENT_RENDER)
          begin
            if (hdr.ptype == cmd_streamer_pkg::TYPE_3D)
              dest_d = cmd_streamer_pkg::D_VF;
            else if (hdr.ptype == cmd_streamer_pkg::TYPE_PIPESEL && hdr.opc == cmd_streamer_pkg::OPC_PIPESEL
                     && hdr.sub == cmd_streamer_pkg::SUB_PIPESEL)
              mode_d = hdr.ctl[0];
            else
              dest_d = cmd_streamer_pkg::D_CMP;
          end
          else if (hdr.client == cmd_streamer_pkg::CLIENT_MI
                   && {hdr.ptype, hdr.opc, hdr.sub[7]} == cmd_streamer_pkg::MI_SEMA_WAIT)
            sema_d = 1'b1;
          st_d = (hdr.len == 8'h00) ? cmd_streamer_pkg::P_DONE : cmd_streamer_pkg::P_BODY;
        end
      cmd_streamer_pkg::P_BODY:
        if (!fifo_empty && (dest_q == cmd_streamer_pkg::D_SELF
            || (dest_q == cmd_streamer_pkg::D_VF && vf_free) || (dest_q == cmd_streamer_pkg::D_CMP && cm_free)))
        begin
          consume = 1'b1;
          if (dest_q == cmd_streamer_pkg::D_VF)
          begin
            vfv_d = 1'b1;
            vfp_d = '{data: cur_dw, last: rem_q == 8'h01};
          end
          if (dest_q == cmd_streamer_pkg::D_CMP)
          begin
            cmv_d = 1'b1;
            cmp_d = '{data: cur_dw, last: rem_q == 8'h01};
          end
          rem_d = rem_q - 8'h01;
          ndw_d = ndw_q + 9'h001;
          if (rem_q == 8'h01)
            st_d = cmd_streamer_pkg::P_DONE;
        end
      cmd_streamer_pkg::P_DONE:
        if (!vfv_q && !cmv_q && (!sema_q || sema_i))
        begin
          head_d = head_sum;
          st_d = cmd_streamer_pkg::P_HDR;
        end
    endcase
    pos_d = pos_q + 4'(consume);
    if (flush)
    begin
      pos_d = 4'h0;
      head_d = cmd_streamer_pkg::PTR_RST;
    end
    empty_d = (head_d == tail_d);
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      start_q <= cmd_streamer_pkg::PTR_RST;
      len_q <= cmd_streamer_pkg::RING_LEN_RST;
      tail_q <= cmd_streamer_pkg::PTR_RST;
      head_q <= cmd_streamer_pkg::PTR_RST;
      dma_head_q <= cmd_streamer_pkg::PTR_RST;
      addr_q <= cmd_streamer_pkg::PTR_RST;
      fetch_en_q <= 1'b0;
      stop_q <= 1'b0;
      ack_q <= 1'b0;
      claim_q <= 1'b0;
      req_q <= 1'b0;
      infl_q <= 4'h0;
      empty_q <= 1'b1;
      mode_q <= 1'b1;
      sema_q <= 1'b0;
      pos_q <= 4'h0;
      rem_q <= 8'h00;
      ndw_q <= 9'h000;
      vfv_q <= 1'b0;
      cmv_q <= 1'b0;
      vfp_q <= '0;
      cmp_q <= '0;
      st_q <= cmd_streamer_pkg::P_HDR;
      dest_q <= cmd_streamer_pkg::D_SELF;
    end
    else
    begin
      start_q <= start_d;
      len_q <= len_d;
      tail_q <= tail_d;
      head_q <= head_d;
      dma_head_q <= dma_head_d;
      addr_q <= addr_d;
      fetch_en_q <= fetch_en_d;
      stop_q <= stop_d;
      ack_q <= ack_d;
      claim_q <= claim_d;
      req_q <= req_d;
      infl_q <= infl_d;
      empty_q <= empty_d;
      mode_q <= mode_d;
      sema_q <= sema_d;
      pos_q <= pos_d;
      rem_q <= rem_d;
      ndw_q <= ndw_d;
      vfv_q <= vfv_d;
      cmv_q <= cmv_d;
      vfp_q <= vfp_d;
      cmp_q <= cmp_d;
      st_q <= st_d;
      dest_q <= dest_d;
    end
  end

  assign mmio_claim_o = claim_q;
  assign mem_req_valid_o = req_q;
  assign mem_req_addr_o = addr_q;
  assign vf_valid_o = vfv_q;
  assign vf_pkt_o = vfp_q;
  assign cmp_valid_o = cmv_q;
  assign cmp_pkt_o = cmp_q;
  assign ctx_switch_ack_o = ack_q;
  assign head_o = head_q;
  assign ring_empty_o = empty_q;
  assign mode_3d_o = mode_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_claim_window: assert property (mmio_claim_o |-> $past(mmio_valid_i)
    && $past(mmio_i.addr) >= 32'h0000_2000 && $past(mmio_i.addr) <= 32'h0000_27FF) else $error("claim outside window");
  a_tail_kicks: assert property (mmio_valid_i && mmio_i.addr == 32'h0000_2030 |=> fetch_en_q)
    else $error("tail write did not enable fetch");
  a_req_addr: assert property ($rose(mem_req_valid_o) |-> mem_req_addr_o == $past(start_q + dma_head_q))
    else $error("fetch address not start plus head");
  a_slot_reserved: assert property (fifo_cnt + infl_q <= 4'h8) else $error("fifo over-reserved");
  a_dma_head_step: assert property (mem_req_valid_o && mem_req_ready_i && !(mmio_valid_i && claim_d)
    |=> dma_head_q == $past(dma_next) && !mem_req_valid_o) else $error("dma head not stepped");
  a_stop_at_tail: assert property ($rose(mem_req_valid_o) |-> $past(dma_head_q != tail_q))
    else $error("request issued at tail");
  a_stall_empty: assert property (fifo_empty |-> !consume) else $error("parser consumed from empty fifo");
  a_hdr_stripped: assert property ($rose(vf_valid_o) |-> $past(st_q == cmd_streamer_pkg::P_BODY))
    else $error("header reached vertex fetch");
  a_head_on_done: assert property (head_q != $past(head_q)
    |-> $past(st_q == cmd_streamer_pkg::P_DONE) || $past(flush)) else $error("head moved before completion");
  a_empty_flag: assert property (ring_empty_o == (head_q == tail_q)) else $error("empty flag wrong");
  a_route_3d: assert property (st_q == cmd_streamer_pkg::P_HDR && consume
    && hdr.client == 3'h3 && hdr.ptype == 2'h3
    |=> dest_q == cmd_streamer_pkg::D_VF) else $error("3D header not routed to vertex fetch");
  c_vf_last: cover property (vf_valid_o && vf_ready_i && vf_pkt_o.last);
  c_cmp_pkt: cover property (cmp_valid_o && cmp_ready_i);
  c_sema_wait: cover property (st_q == cmd_streamer_pkg::P_DONE && sema_q && !sema_i ##1 sema_i);
  c_ctx_ack: cover property ($rose(ctx_switch_ack_o));
endmodule

// ===== testbench/ring_mem_model.sv
// Memory model for the fetch port: one whole fetch line per accepted request, in order.
// Assumes the requester holds valid and address until ready; slow_i adds wait states.
`timescale 1ns/1ps
module ring_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Request side
  input wire logic slow_i,
  input wire logic req_valid_i,
  input wire logic [31:0] req_addr_i,
  output logic req_ready_o,
  // Return side
  output logic rsp_valid_o,
  output logic [cmd_streamer_pkg::LINE_BITS-1:0] rsp_line_o
);
  logic [31:0] mem [0:511];
  logic [31:0] pend [$];
  logic [31:0] a;
  int wait_n;
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_line_o <= '0;
      wait_n = 0;
      pend.delete();
    end
    else
    begin
      if (req_valid_i && req_ready_o)
        pend.push_back(req_addr_i);
      req_ready_o <= req_valid_i && !req_ready_o && (wait_n >= (slow_i ? 3 : 0));
      wait_n = (req_valid_i && !req_ready_o) ? wait_n + 1 : 0;
      // Between returns the data lines toggle so a stale line is never mistaken for fresh.
      if (pend.size() > 0 && !rsp_valid_o)
      begin
        a = pend.pop_front();
        for (int k = 0; k < 16; k++)
          rsp_line_o[32*k +: 32] <= mem[a[10:2] + k];
        rsp_valid_o <= 1'b1;
      end
      else
      begin
        rsp_valid_o <= 1'b0;
        rsp_line_o <= ~rsp_line_o;
      end
    end
  end
endmodule

// ===== testbench/ring_command_fetch_parser_test.sv
// Self-checking bench for the ring command fetch parser.
// Assumes the memory model beside it and drives the packet sinks itself.
`timescale 1ns/1ps
module ring_command_fetch_parser_test;
  logic clk, rst_n, mmio_v, mem_rdy, rsp_v, vf_rdy, cmp_rdy, sema, ctx, slow;
  logic claim, req_v, vf_v, cmp_v, ack, empty, m3d;
  logic [31:0] req_a, head;
  logic [cmd_streamer_pkg::LINE_BITS-1:0] rsp_line;
  cmd_streamer_pkg::mmio_t mmio;
  cmd_streamer_pkg::pkt_t vf_p, cmp_p;
  logic [31:0] req_q [$];
  cmd_streamer_pkg::pkt_t vf_q [$], cmp_q [$];
  int fails = 0;
  int n_tests = 0;

  ring_command_fetch_parser dut (.clk_i(clk), .reset_n_i(rst_n), .mmio_valid_i(mmio_v), .mmio_i(mmio),
    .mmio_claim_o(claim), .mem_req_valid_o(req_v), .mem_req_addr_o(req_a), .mem_req_ready_i(mem_rdy),
    .mem_rsp_valid_i(rsp_v), .mem_rsp_line_i(rsp_line), .vf_valid_o(vf_v), .vf_pkt_o(vf_p),
    .vf_ready_i(vf_rdy), .cmp_valid_o(cmp_v), .cmp_pkt_o(cmp_p), .cmp_ready_i(cmp_rdy), .sema_i(sema),
    .ctx_switch_i(ctx), .ctx_switch_ack_o(ack), .head_o(head), .ring_empty_o(empty), .mode_3d_o(m3d));
  ring_mem_model mdl (.clk_i(clk), .reset_n_i(rst_n), .slow_i(slow), .req_valid_i(req_v),
    .req_addr_i(req_a), .req_ready_o(mem_rdy), .rsp_valid_o(rsp_v), .rsp_line_o(rsp_line));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (req_v && mem_rdy)
      req_q.push_back(req_a);
    if (vf_v && vf_rdy)
      vf_q.push_back(vf_p);
    if (cmp_v && cmp_rdy)
      cmp_q.push_back(cmp_p);
  end

  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok)
    begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic c);
    @(posedge clk);
    #1;
    mmio_v = 1'b1;
    mmio = {a, d};
    cyc(1);
    mmio_v = 1'b0;
    c = claim;
  endtask

  task automatic wait_empty;
    int i;
    i = 0;
    do
    begin
      cyc(1);
      i++;
    end while (empty !== 1'b1 && i < 1500);
    chk(empty === 1'b1, "ring did not drain");
  endtask

  task automatic t_window;
    logic c;
    wr(32'h0000_1030, 32'h0000_0040, c);
    chk(c === 1'b0, "claim below window");
    wr(32'h0000_2830, 32'h0000_0040, c);
    chk(c === 1'b0, "claim above window");
    cyc(3);
    chk(empty === 1'b1, "outside write took effect");
    wr(32'h0000_2000, 32'h0000_0000, c);
    chk(c === 1'b1, "no claim at low end");
    wr(32'h0000_27FF, 32'h0000_0000, c);
    chk(c === 1'b1, "no claim at high end");
    chk(head === 32'h0 && m3d === 1'b1, "reset state");
  endtask

  task automatic t_ring_run;
    logic c;
    mdl.mem[16] = 32'h7800_0002;
    mdl.mem[17] = 32'hA000_0001;
    mdl.mem[18] = 32'hA000_0002;
    mdl.mem[19] = 32'h7000_0001;
    mdl.mem[20] = 32'hB000_0001;
    mdl.mem[21] = 32'h6904_0000;
    mdl.mem[22] = 32'h0E00_0000;
    mdl.mem[23] = 32'h0000_0001;
    mdl.mem[24] = 32'hC000_0001;
    wr(cmd_streamer_pkg::RING_START_OFS, 32'h0000_0040, c);
    wr(cmd_streamer_pkg::RING_LEN_OFS, 32'h0000_0100, c);
    wr(cmd_streamer_pkg::RING_TAIL_OFS, 32'h0000_0040, c);
    cyc(30);
    chk(head === 32'h0 && empty === 1'b0, "head moved before completion");
    chk(req_q.size() == 1 && req_q[0] === 32'h0000_0040, "fetch request set");
    chk(vf_v === 1'b1 && vf_p === {32'hA000_0001, 1'b0}, "first body dword");
    vf_rdy = 1'b1;
    cyc(40);
    chk(vf_q.size() == 2 && vf_q[1] === {32'hA000_0002, 1'b1}, "3D packet");
    chk(cmp_q.size() == 1 && cmp_q[0] === {32'hB000_0001, 1'b1}, "compute packet");
    chk(m3d === 1'b0, "pipeline select");
    chk(head === 32'h0000_0018, "head during semaphore wait");
    sema = 1'b1;
    wait_empty();
    chk(head === 32'h0000_0040, "head at tail");
    chk(vf_q.size() == 2 && cmp_q.size() == 1, "parser-own command forwarded");
  endtask

  task automatic t_wrap;
    logic c;
    req_q.delete();
    slow = 1'b1;
    ctx = 1'b1;
    cyc(1);
    ctx = 1'b0;
    cyc(20);
    chk(ack === 1'b1, "context switch not acknowledged");
    wr(cmd_streamer_pkg::RING_TAIL_OFS, 32'h0000_0000, c);
    cyc(2);
    chk(ack === 1'b0, "ack not cleared");
    wait_empty();
    chk(req_q.size() == 3 && req_q[0] === 32'h0000_0080 && req_q[2] === 32'h0000_0100, "wrap fetch");
    chk(head === 32'h0, "head did not wrap");
  endtask

  task automatic t_fifo;
    logic c;
    for (int k = 0; k < 512; k++)
      mdl.mem[k] = 32'h0;
    mdl.mem[0] = 32'h7800_0002;
    req_q.delete();
    slow = 1'b0;
    vf_rdy = 1'b0;
    wr(cmd_streamer_pkg::RING_START_OFS, 32'h0000_0000, c);
    wr(cmd_streamer_pkg::RING_LEN_OFS, 32'h0000_0400, c);
    wr(cmd_streamer_pkg::RING_TAIL_OFS, 32'h0000_03C0, c);
    cyc(100);
    // The line under the parser stays in its FIFO slot, so exactly eight lines are asked for.
    chk(req_q.size() == 8, "fetch beyond FIFO room");
    vf_rdy = 1'b1;
    wait_empty();
    chk(req_q.size() == 15 && req_q[14] === 32'h0000_0380, "fetch stop");
    chk(head === 32'h0000_03C0, "final head");
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #800000;
    fails++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    mmio_v = 1'b0;
    mmio = '0;
    vf_rdy = 1'b0;
    cmp_rdy = 1'b1;
    sema = 1'b0;
    ctx = 1'b0;
    slow = 1'b0;
    for (int k = 0; k < 512; k++)
      mdl.mem[k] = 32'h0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(empty === 1'b1, "not empty after reset");
    t_window();
    t_ring_run();
    t_wrap();
    t_fifo();
    tally_and_finish();
  end
endmodule
